// >>> pkg/led_seq_regs.svh
// Constants of the sequential bypass switch controller
//
// Notes on behaviour
// - While enable is low every bypass switch stays open, all LEDs lit.
// - Enable is pulled low at power-up until the charge pump regulates.
// - Switch sequencing starts when enable rises.
// - Host may hold enable low indefinitely; switches stay open throughout.
// - Enable is a wired-AND open-drain net shared by several controllers.
// - Open and short LED detection is disabled while enable is low.
// - Fault flag is pulled low while any LED or thermal fault persists.
// - A switch off lights its LEDs; a switch on shunts them dark.
// - The six switches form two groups of three.
// - Chaining line is open-drain, shared by all controllers.
// - One more switch changes per step; end state held until enable goes low.
// - Direction 0 closes from top switch; direction 1 starts closed, opens.
// - Position N waits N chain pulses; releases chain line when done.
`ifndef LED_SEQ_REGS_SVH
`define LED_SEQ_REGS_SVH

// Clock rate and step period
`define SEQ_CLK_MHZ       100
`define SEQ_STEP_TIME_US  2000
`define SEQ_STEP_CYCLES   (`SEQ_STEP_TIME_US * `SEQ_CLK_MHZ)
`define SEQ_STEP_CNT_W    20

// Switch layout
`define SEQ_SWITCHES      6
`define SEQ_GROUP_SIZE    3
`define SEQ_LAST_STEP     3'h6

// Strap fields and their reset values
`define SEQ_DIR_BIT       3
`define SEQ_POS_W         4
`define SEQ_DIR_RST       1'b0
`define SEQ_POS_RST       4'h0

`endif

// >>> pkg/led_seq_pkg.sv
// Types shared by the sequence controller and its switch bank
`include "led_seq_regs.svh"

package led_seq_pkg;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        ST_POWERUP = 5'b00001,
        ST_IDLE    = 5'b00010,
        ST_WAIT    = 5'b00100,
        ST_RUN     = 5'b01000,
        ST_DONE    = 5'b10000
    } seq_state_e;

    typedef logic [`SEQ_SWITCHES-1:0] switch_vec_t;
    typedef logic [2:0]               step_t;
    typedef logic [`SEQ_POS_W-1:0]    pos_t;

endpackage

// >>> pkg/switch_drive_if.sv
// Carrier between the sequence controller and the bypass switch bank
`timescale 1ns/100ps

interface switch_drive_if;
    logic                      active;    // Enabled and waiting, sequencing or done
    logic                      dir_up;    // Start closed, open one by one
    led_seq_pkg::step_t        step_idx;  // Steps completed so far
    led_seq_pkg::switch_vec_t  bypass_on; // 1 = switch on, LEDs shunted

    modport ctrl (
        output active,
        output dir_up,
        output step_idx,
        input  bypass_on
    );

    modport bank (
        input  active,
        input  dir_up,
        input  step_idx,
        output bypass_on
    );
endinterface

// >>> hdl/bypass_switch_bank.sv
// Registered gate commands for the six bypass switches
`timescale 1ns/100ps
`include "led_seq_regs.svh"

module bypass_switch_bank (
    input  wire logic     core_clk_i,
    input  wire logic     reset_n_i,
    switch_drive_if.bank  sw
);

    // Switch i+1 belongs to group i/3; the top switch changes first
    genvar i;
    generate
        for (i = 0; i < `SEQ_SWITCHES; i++) begin : g_sw
            localparam led_seq_pkg::step_t ORDER =
                led_seq_pkg::step_t'(`SEQ_SWITCHES - 1 - i);
            logic changed;
            assign changed = (sw.step_idx > ORDER);
            // On shunts its LEDs, off lights them
            always_ff @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    sw.bypass_on[i] <= 1'b0;
                end else if (!sw.active) begin
                    sw.bypass_on[i] <= 1'b0;
                end else begin
                    sw.bypass_on[i] <= sw.dir_up ^ changed;
                end
            end
        end
    endgenerate

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_start_pattern:
        assert property ((sw.active && sw.step_idx == 3'h0) |=>
            (sw.bypass_on == (sw.dir_up ? 6'h3f : 6'h00)))
        else $error("switches not at their starting pattern");

    a_top_first:
        assert property ((sw.active && sw.step_idx == 3'h1) |=>
            (sw.bypass_on[5] == !sw.dir_up && sw.bypass_on[4] == sw.dir_up))
        else $error("first step did not change the top switch only");

endmodule

// >>> hdl/led_sequence_enable_fault_ctrl.sv
// Enable, chaining, fault flag and step control of the LED bypass sequencer
`timescale 1ns/100ps
`include "led_seq_regs.svh"

module led_sequence_enable_fault_ctrl #(
    parameter int STEP_CYCLES = `SEQ_STEP_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        pump_ok_i,
    input  wire logic [3:0]  threshold_direction_cfg_i,
    input  wire logic [3:0]  chain_position_cfg_i,
    input  wire logic        enable_i,
    output      logic        enable_o,
    output      logic        enable_oe_o,
    input  wire logic        sync_i,
    output      logic        sync_o,
    output      logic        sync_oe_o,
    input  wire logic        thermal_shdn_i,
    input  wire logic [5:0]  open_led_i,
    input  wire logic [5:0]  short_led_i,
    output      logic        fault_flag_n_o,
    output      logic        fault_flag_n_oe_o,
    output      logic [5:0]  bypass_on_o
);

    localparam int CNT_W = `SEQ_STEP_CNT_W;
    localparam int PIN_W = 24;

    led_seq_pkg::seq_state_e   state;
    led_seq_pkg::seq_state_e   next_state;
    logic [PIN_W-1:0]          pin_meta;
    logic [PIN_W-1:0]          pin_sync;
    logic                      en_s;
    logic                      en_d;
    logic                      en_rise;
    logic                      chain_s;
    logic                      chain_d;
    logic                      chain_rise;
    logic                      pump_s;
    logic                      therm_s;
    logic [5:0]                open_s;
    logic [5:0]                short_s;
    logic [3:0]                dir_cfg_s;
    logic [3:0]                pos_cfg_s;
    logic                      dir_up;
    led_seq_pkg::pos_t         position;
    led_seq_pkg::pos_t         pulse_cnt;
    logic [CNT_W-1:0]          step_cnt;
    logic                      step_tick;
    led_seq_pkg::step_t        step_idx;
    logic                      fault_now;

    switch_drive_if sw ();

    // Two-stage synchroniser for every pin input
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {chain_position_cfg_i, threshold_direction_cfg_i,
                         short_led_i, open_led_i, thermal_shdn_i,
                         pump_ok_i, sync_i, enable_i};
            pin_sync <= pin_meta;
        end
    end

    // Unpack synchronised pins; enable is the wired-AND level of the net
    assign en_s      = pin_sync[0];
    assign chain_s   = pin_sync[1];
    assign pump_s    = pin_sync[2];
    assign therm_s   = pin_sync[3];
    assign open_s    = pin_sync[9:4];
    assign short_s   = pin_sync[15:10];
    assign dir_cfg_s = pin_sync[19:16];
    assign pos_cfg_s = pin_sync[23:20];

    // Edge history of enable and chaining line
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_d    <= 1'b0;
            chain_d <= 1'b0;
        end else begin
            en_d    <= en_s;
            chain_d <= chain_s;
        end
    end

    assign en_rise    = en_s && !en_d;
    assign chain_rise = chain_s && !chain_d;

    // Straps are sampled only while powering up
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_up   <= `SEQ_DIR_RST;
            position <= `SEQ_POS_RST;
        end else if (state == led_seq_pkg::ST_POWERUP) begin
            dir_up   <= dir_cfg_s[`SEQ_DIR_BIT];
            position <= pos_cfg_s;
        end
    end

    // Next state of the sequence controller
    always_comb begin
        next_state = state;
        case (state)
            led_seq_pkg::ST_POWERUP: begin
                if (pump_s) begin
                    next_state = led_seq_pkg::ST_IDLE;
                end
            end
            led_seq_pkg::ST_IDLE: begin
                if (en_rise) begin
                    if (position == 4'h0) begin
                        next_state = led_seq_pkg::ST_RUN;
                    end else begin
                        next_state = led_seq_pkg::ST_WAIT;
                    end
                end
            end
            led_seq_pkg::ST_WAIT: begin
                if (!en_s) begin
                    next_state = led_seq_pkg::ST_IDLE;
                end else if (chain_rise &&
                             pulse_cnt == position - 4'h1) begin
                    next_state = led_seq_pkg::ST_RUN;
                end
            end
            led_seq_pkg::ST_RUN: begin
                if (!en_s) begin
                    next_state = led_seq_pkg::ST_IDLE;
                end else if (step_tick &&
                             step_idx == `SEQ_LAST_STEP - 3'h1) begin
                    next_state = led_seq_pkg::ST_DONE;
                end
            end
            led_seq_pkg::ST_DONE: begin
                if (!en_s) begin
                    next_state = led_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = led_seq_pkg::ST_POWERUP;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= led_seq_pkg::ST_POWERUP;
        end else begin
            state <= next_state;
        end
    end

    // Counts chain pulses while waiting for this device's turn
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pulse_cnt <= '0;
        end else if (state != led_seq_pkg::ST_WAIT) begin
            pulse_cnt <= '0;
        end else if (chain_rise) begin
            pulse_cnt <= pulse_cnt + 4'h1;
        end
    end

    // Step period timer, runs only while sequencing
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_cnt <= '0;
        end else if (state != led_seq_pkg::ST_RUN || step_tick) begin
            step_cnt <= '0;
        end else begin
            step_cnt <= step_cnt + 1'b1;
        end
    end

    assign step_tick = (state == led_seq_pkg::ST_RUN) &&
                       (step_cnt == CNT_W'(STEP_CYCLES - 1));

    // One more switch changes at the end of each step; held when done
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_idx <= '0;
        end else if (state != led_seq_pkg::ST_RUN &&
                     state != led_seq_pkg::ST_DONE) begin
            step_idx <= '0;
        end else if (step_tick) begin
            step_idx <= step_idx + 3'h1;
        end
    end

    // Switch bank drive; inactive means every switch open
    assign sw.active   = (state == led_seq_pkg::ST_WAIT) ||
                         (state == led_seq_pkg::ST_RUN)  ||
                         (state == led_seq_pkg::ST_DONE);
    assign sw.dir_up   = dir_up;
    assign sw.step_idx = step_idx;

    bypass_switch_bank u_bank (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .sw         (sw.bank)
    );

    assign bypass_on_o = sw.bypass_on;

    // LED faults count only while enabled; thermal always counts
    assign fault_now = therm_s || (en_s && |(open_s | short_s));

    // Open-drain pulls: enable at power-up, chain while running, fault
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enable_oe_o       <= 1'b1;
            sync_oe_o         <= 1'b0;
            fault_flag_n_oe_o <= 1'b0;
        end else begin
            enable_oe_o       <= next_state == led_seq_pkg::ST_POWERUP;
            sync_oe_o         <= next_state == led_seq_pkg::ST_RUN;
            fault_flag_n_oe_o <= fault_now;
        end
    end

    // Open-drain pins only ever drive low
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enable_o       <= 1'b0;
            sync_o         <= 1'b0;
            fault_flag_n_o <= 1'b0;
        end else begin
            enable_o       <= 1'b0;
            sync_o         <= 1'b0;
            fault_flag_n_o <= 1'b0;
        end
    end

    // Checks on the controller
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_open_when_low:
        assert property ((!en_s [*2]) |=> (bypass_on_o == 6'h00))
        else $error("switch closed while enable low");

    // Enable may come back at any time, so only the next cycle is bound
    a_hazard_hold:
        assert property ((!en_s && state != led_seq_pkg::ST_POWERUP)
            |=> (!sw.active && state == led_seq_pkg::ST_IDLE))
        else $error("sequencing resumed during hazard hold");

    a_pull_in_powerup:
        assert property ((state == led_seq_pkg::ST_POWERUP) |-> enable_oe_o)
        else $error("enable released before pump in regulation");

    a_release_on_pump:
        assert property ($fell(enable_oe_o) |-> $past(pump_s))
        else $error("enable released without pump good");

    a_start_on_rise:
        assert property ((state == led_seq_pkg::ST_IDLE && en_rise &&
            position == 4'h0) |=> (state == led_seq_pkg::ST_RUN))
        else $error("sequence did not start on enable rise");

    a_fault_gated:
        assert property ((!en_s && !therm_s) |=> !fault_flag_n_oe_o)
        else $error("LED fault reported while enable low");

    a_fault_held:
        assert property ((therm_s || (en_s && |(open_s | short_s)))
            |=> fault_flag_n_oe_o)
        else $error("fault present but fault flag released");

    a_chain_low_run:
        assert property ((state == led_seq_pkg::ST_RUN) |-> sync_oe_o)
        else $error("chain line not held low while sequencing");

    a_chain_release:
        assert property ((state == led_seq_pkg::ST_RUN &&
            next_state == led_seq_pkg::ST_DONE) |=> !sync_oe_o)
        else $error("chain line not released at sequence end");

    a_step_advance:
        assert property (step_tick |=> (step_idx == $past(step_idx) + 3'h1))
        else $error("step index did not advance on step tick");

    a_done_holds:
        assert property ((state == led_seq_pkg::ST_DONE && en_s)
            |=> (state == led_seq_pkg::ST_DONE &&
                 step_idx == `SEQ_LAST_STEP))
        else $error("ending state not held");

    a_chain_start:
        assert property ((state == led_seq_pkg::ST_WAIT && en_s &&
            chain_rise && pulse_cnt == position - 4'h1)
            |=> (state == led_seq_pkg::ST_RUN))
        else $error("device did not start on its chain pulse");

    a_no_early_start:
        assert property ((state == led_seq_pkg::ST_WAIT &&
            pulse_cnt + 4'h1 < position)
            |=> (state != led_seq_pkg::ST_RUN))
        else $error("device started before its chain turn");

    // Main scenarios
    c_full_sequence:
        cover property (state == led_seq_pkg::ST_RUN &&
            next_state == led_seq_pkg::ST_DONE);

    c_chained_start:
        cover property (state == led_seq_pkg::ST_WAIT &&
            next_state == led_seq_pkg::ST_RUN);

    c_hazard_abort:
        cover property (state == led_seq_pkg::ST_RUN && !en_s);

    c_fault_flag:
        cover property (en_s && |(open_s | short_s) ##1 fault_flag_n_oe_o);

endmodule

// >>> testbench/led_env_model.sv
// Shared enable and chaining nets with pull-ups, host and chained peer
`timescale 1ns/100ps

module led_env_model (
    input  wire logic enable_drv_i,  // Device data on enable pin
    input  wire logic enable_oe_i,   // Device drives enable pin
    input  wire logic host_low_i,    // Host forces hazard lighting
    input  wire logic sync_drv_i,    // Device data on chaining pin
    input  wire logic sync_oe_i,     // Device drives chaining pin
    input  wire logic peer_low_i,    // Chained controller pulls chain low
    output      logic enable_net_o,
    output      logic sync_net_o
);
    // Released pins float to the pull-up; any driver low wins the net
    assign enable_net_o = (enable_oe_i ? enable_drv_i : 1'b1)
                        & ~host_low_i;
    assign sync_net_o   = (sync_oe_i ? sync_drv_i : 1'b1)
                        & ~peer_low_i;
endmodule

// >>> testbench/led_sequence_enable_fault_ctrl_bench.sv
// Self-checking bench of the LED sequence enable and fault controller
`timescale 1ns/100ps

`define CHECK(act, exp) begin \
    samples_checked++; \
    if ((act) !== (exp)) begin \
        errors++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, act, exp); \
    end \
end

module led_sequence_enable_fault_ctrl_bench;
    localparam int STEP = 8;

    typedef struct packed {
        logic       en_low;
        logic       hot;
        logic [5:0] open_led;
        logic [5:0] short_led;
        logic       fault_flag_n;
    } row_s;

    logic       core_clk_i = 1'b0;
    logic       reset_n_i  = 1'b0;
    logic       pump_ok    = 1'b0;
    logic [3:0] dir_cfg    = 4'h0;
    logic [3:0] pos_cfg    = 4'h0;
    logic       thermal    = 1'b0;
    logic [5:0] open_led   = 6'h00;
    logic [5:0] short_led  = 6'h00;
    logic       host_low   = 1'b0;
    logic       peer_low   = 1'b0;
    logic       enable_net;
    logic       sync_net;
    logic       enable_drv;
    logic       enable_oe;
    logic       sync_drv;
    logic       sync_oe;
    logic       flt_drv;
    logic       flt_oe;
    logic [5:0] bypass;
    int         errors          = 0;
    int         samples_checked = 0;

    // Fault cases: enable state and fault inputs against the flag
    row_s rows [7] = '{
        '{1'b0, 1'b0, 6'h04, 6'h00, 1'b1},
        '{1'b1, 1'b0, 6'h04, 6'h00, 1'b0},
        '{1'b1, 1'b1, 6'h00, 6'h00, 1'b1},
        '{1'b0, 1'b0, 6'h00, 6'h20, 1'b1},
        '{1'b0, 1'b0, 6'h00, 6'h00, 1'b0},
        '{1'b1, 1'b0, 6'h00, 6'h3f, 1'b0},
        '{1'b0, 1'b1, 6'h00, 6'h00, 1'b1}
    };

    // Clock of 100 MHz
    always #5 core_clk_i = ~core_clk_i;

    led_sequence_enable_fault_ctrl #(
        .STEP_CYCLES (STEP)
    ) u_dut (
        .core_clk_i                (core_clk_i),
        .reset_n_i                 (reset_n_i),
        .pump_ok_i                 (pump_ok),
        .threshold_direction_cfg_i (dir_cfg),
        .chain_position_cfg_i      (pos_cfg),
        .enable_i                  (enable_net),
        .enable_o                  (enable_drv),
        .enable_oe_o               (enable_oe),
        .sync_i                    (sync_net),
        .sync_o                    (sync_drv),
        .sync_oe_o                 (sync_oe),
        .thermal_shdn_i            (thermal),
        .open_led_i                (open_led),
        .short_led_i               (short_led),
        .fault_flag_n_o            (flt_drv),
        .fault_flag_n_oe_o         (flt_oe),
        .bypass_on_o               (bypass)
    );

    led_env_model u_env (
        .enable_drv_i (enable_drv),
        .enable_oe_i  (enable_oe),
        .host_low_i   (host_low),
        .sync_drv_i   (sync_drv),
        .sync_oe_i    (sync_oe),
        .peer_low_i   (peer_low),
        .enable_net_o (enable_net),
        .sync_net_o   (sync_net)
    );

    // Pattern after the n-th change of the switch bank (direction 1) or the (n+1)-th (direction 0)
    function automatic logic [5:0] exp_pat(input logic d, input int n);
        logic [5:0] top;
        if (d) begin
            if (n == 0) begin
                return 6'h3f;
            end
            top = 6'h3f << (6 - n);
            return ~top;
        end
        top = 6'h3f << (5 - n);
        return top;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic report_and_stop();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reset with straps, then let the charge pump come good
    task automatic do_reset(input logic [3:0] dcfg, input logic [3:0] pcfg);
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        pump_ok   <= 1'b0;
        dir_cfg   <= dcfg;
        pos_cfg   <= pcfg;
        tick(16);
        #1;
        `CHECK({enable_oe, sync_oe, flt_oe, bypass}, 9'h100)
        @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        tick(20);
        #1;
        `CHECK({enable_oe, enable_drv, bypass}, 8'h80)
        @(posedge core_clk_i);
        pump_ok <= 1'b1;
        tick(4);
        #1;
        `CHECK(enable_oe, 1'b0)
    endtask

    // Follow one run: each change, its length and the held end state
    task automatic run_check(input logic d, input int nexp);
        int         n;
        int         w;
        int         hi;
        logic [5:0] prev;
        n  = d ? 1 : 0;
        w  = 0;
        hi = 1;
        while (sync_oe !== 1'b1 && w < 20) begin
            @(posedge core_clk_i);
            #1;
            w++;
        end
        `CHECK({sync_oe, sync_drv}, 2'h2)
        `CHECK(bypass, d ? 6'h3f : 6'h00)
        prev = d ? 6'h3f : 6'h00;
        repeat (6 * STEP + 16) begin
            @(posedge core_clk_i);
            #1;
            if (sync_oe === 1'b1) begin
                hi++;
            end
            if (bypass !== prev) begin
                `CHECK(bypass, exp_pat(d, n))
                n++;
                prev = bypass;
            end
        end
        `CHECK(n, nexp)
        `CHECK(hi, 6 * STEP)
        `CHECK(bypass, d ? 6'h00 : 6'h3f)
    endtask

    task automatic chain_pulse();
        @(posedge core_clk_i);
        peer_low <= 1'b1;
        tick(3);
        peer_low <= 1'b0;
        tick(10);
        #1;
    endtask

    // Main sequence
    initial begin
        do_reset(4'h0, 4'h0);
        run_check(1'b0, 6);
        tick(20);
        #1;
        `CHECK(bypass, 6'h3f)
        foreach (rows[i]) begin
            @(posedge core_clk_i);
            host_low  <= rows[i].en_low;
            thermal   <= rows[i].hot;
            open_led  <= rows[i].open_led;
            short_led <= rows[i].short_led;
            tick(4);
            #1;
            `CHECK({flt_oe, flt_drv}, {rows[i].fault_flag_n, 1'b0})
            if (rows[i].en_low) begin
                `CHECK(bypass, 6'h00)
            end
        end
        // Hazard hold: host keeps the shared net low with device released
        @(posedge core_clk_i);
        host_low <= 1'b1;
        thermal  <= 1'b0;
        tick(4);
        repeat (100) begin
            @(posedge core_clk_i);
            #1;
            `CHECK({enable_oe, sync_oe, bypass}, 8'h00)
        end
        // Restart, then abort in mid-run
        @(posedge core_clk_i);
        host_low <= 1'b0;
        tick(5 + 2 * STEP);
        #1;
        `CHECK(sync_oe, 1'b1)
        @(posedge core_clk_i);
        host_low <= 1'b1;
        tick(5);
        #1;
        `CHECK({sync_oe, bypass}, 7'h00)
        @(posedge core_clk_i);
        host_low <= 1'b0;
        // Direction 1 at chain position 2
        do_reset(4'h8, 4'h2);
        tick(20);
        #1;
        `CHECK(sync_oe, 1'b0)
        chain_pulse();
        `CHECK(sync_oe, 1'b0)
        // Second pulse: follow the run from its very first cycle
        @(posedge core_clk_i);
        peer_low <= 1'b1;
        tick(3);
        peer_low <= 1'b0;
        run_check(1'b1, 7);
        chain_pulse();
        `CHECK({sync_oe, sync_drv, bypass}, 8'h00)
        report_and_stop();
    end

    // Watchdog against a hang
    initial begin
        tick(20000);
        errors++;
        report_and_stop();
    end
endmodule
